// ==== bfle_pkg.sv ====
// Purpose: shared constants and types of the bit, flag and load executor
// Assumes: 8-bit registers held as 16 register pairs
// Notes:   flag positions follow the status byte layout I T H S V N Z C
package bfle_pkg;

	// ****************************************************************
	// status flag positions
	// ****************************************************************
	localparam int unsigned FLAG_C = 0;
	localparam int unsigned FLAG_Z = 1;
	localparam int unsigned FLAG_N = 2;
	localparam int unsigned FLAG_V = 3;
	localparam int unsigned FLAG_S = 4;
	localparam int unsigned FLAG_H = 5;
	localparam int unsigned FLAG_T = 6;
	localparam int unsigned FLAG_I = 7;

	// ****************************************************************
	// reset values and register layout
	// ****************************************************************
	localparam logic [15:0] PC_RST    = 16'h0000;
	localparam logic [7:0]  FLAGS_RST = 8'h00;
	localparam logic [15:0] PTR_RST   = 16'h0000;
	localparam logic [15:0] WORD_RST  = 16'h0000;
	localparam logic [7:0]  BYTE_RST  = 8'h00;
	localparam int unsigned RF_PAIRS  = 16;
	localparam logic [3:0]  PAIR_X    = 4'hD;
	localparam logic [3:0]  PAIR_Y    = 4'hE;

	// ****************************************************************
	// decoded operations
	// ****************************************************************
	typedef enum logic [4:0] {
		OP_NOP,
		OP_BR_IRQ_ON,
		OP_BR_IRQ_OFF,
		OP_BR_FLAG_SET,
		OP_BR_FLAG_CLR,
		OP_IO_BIT_SET,
		OP_IO_BIT_CLEAR,
		OP_SHL,
		OP_SHR,
		OP_ROT_LEFT,
		OP_ROT_RIGHT,
		OP_SHR_ARITH,
		OP_SWAP,
		OP_FLAG_SET,
		OP_FLAG_CLR,
		OP_BIT_TO_T,
		OP_T_TO_BIT,
		OP_REG_COPY,
		OP_PAIR_COPY,
		OP_LOAD_CONST,
		OP_LOAD_X,
		OP_LOAD_X_INC,
		OP_LOAD_X_DEC,
		OP_LOAD_Y,
		OP_LOAD_Y_INC,
		OP_LOAD_Y_DEC
	} bfle_op_t;

endpackage : bfle_pkg

// ==== bfle_rf_if.sv ====
// Purpose: carrier between the executor and its register-pair memory
// Assumes: one byte-enabled write and two registered reads per cycle
// Notes:   even register sits in the low byte of a pair
`timescale 1ns/10ps
`default_nettype none

interface bfle_rf_if;
	logic [3:0]  ra_pair;
	logic [3:0]  rb_pair;
	logic [15:0] ra_data;
	logic [15:0] rb_data;
	logic        we_lo;
	logic        we_hi;
	logic [3:0]  wpair;
	logic [15:0] wword;

	modport core (
		output ra_pair, rb_pair, we_lo, we_hi, wpair, wword,
		input  ra_data, rb_data
	);
	modport mem (
		input  ra_pair, rb_pair, we_lo, we_hi, wpair, wword,
		output ra_data, rb_data
	);
endinterface : bfle_rf_if

`default_nettype wire

// ==== bfle_regfile.sv ====
// Purpose: working registers as 16 pairs, two registered read ports
// Assumes: read during write returns the old contents
// Notes:   the executor forwards the last write itself
`timescale 1ns/10ps
`default_nettype none

module bfle_regfile (
	input  wire logic clk_sys,
	input  wire logic rst,
	bfle_rf_if.mem    rf
);
	import bfle_pkg::*;

	logic [15:0] mem_q [RF_PAIRS];

	// ****************************************************************
	// write port
	// ****************************************************************
	always_ff @(posedge clk_sys) begin
		if (rf.we_lo) begin
			mem_q[rf.wpair][7:0] <= rf.wword[7:0];
		end
		if (rf.we_hi) begin
			mem_q[rf.wpair][15:8] <= rf.wword[15:8];
		end
	end

	// ****************************************************************
	// registered read ports
	// ****************************************************************
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			rf.ra_data <= WORD_RST;
			rf.rb_data <= WORD_RST;
		end else begin
			rf.ra_data <= mem_q[rf.ra_pair];
			rf.rb_data <= mem_q[rf.rb_pair];
		end
	end
endmodule : bfle_regfile

`default_nettype wire

// ==== bfle_exec.sv ====
// Purpose: executes branch, bit, shift, flag and pointer-load operations
// Assumes: decoded stream on clk_sys; I/O and data memory answer one cycle after strobe
// Notes:   I/O space must give write-first data when read and write meet
//
// Decided for this implementation: the register offsets and the address-and-strobe port.
`timescale 1ns/10ps
`default_nettype none

// Operation
// - branch_irq_on jumps to pc+k+1 when I is one, flags untouched
// - branch_irq_off jumps to pc+k+1 when I is zero, else falls through
// - io_bit_set and io_bit_clear force one I/O bit, two cycles, no flags
// - shift left: zero into bit 0, updates Z C N V, one cycle
// - shift right: zero into bit 7, updates Z C N V, one cycle
// - rotate left: old carry into bit 0, bit 7 into carry
// - rotate right: old carry into bit 7, bit 0 into carry
// - arithmetic shift right keeps bit 7, updates Z C N V
// - flag set and clear touch only the named flag, one cycle
// - chosen source bit copied into T, no other flag changes
// - T copied into chosen destination bit, flags unchanged
// - load via X then X plus one, two cycles, no flags
// - X minus one first, then load via new X, two cycles
// - load via Y then Y plus one, two cycles, no flags
// - Y minus one first, then load via new Y, two cycles
// - flag branch jumps to pc+k+1 when flag matches, else falls through
module bfle_exec (
	input  wire logic              clk_sys,
	input  wire logic              rst,
	input  wire logic              instr_valid,
	input  wire bfle_pkg::bfle_op_t instr_op,
	input  wire logic [4:0]        instr_rd,
	input  wire logic [4:0]        instr_rr,
	input  wire logic [2:0]        instr_bit,
	input  wire logic [7:0]        instr_imm,
	input  wire logic [6:0]        instr_k,
	input  wire logic [4:0]        instr_io,
	output logic                   instr_ready_q,
	output logic [15:0]            pc_q,
	output logic [7:0]             status_flags_q,
	output logic [4:0]             io_addr_q,
	output logic [7:0]             io_wdata_q,
	output logic                   io_we_q,
	output logic                   io_re_q,
	input  wire logic [7:0]        io_rdata,
	output logic [15:0]            dm_addr_q,
	output logic                   dm_re_q,
	input  wire logic [7:0]        dm_rdata
);
	import bfle_pkg::*;

	// ****************************************************************
	// declarations
	// ****************************************************************
	logic        acc;
	logic        io_op;
	logic        take;
	logic [15:0] k_ext;
	logic        e_valid_q;
	bfle_op_t    e_op_q;
	logic [4:0]  e_rd_q;
	logic [4:0]  e_rr_q;
	logic [2:0]  e_bit_q;
	logic [7:0]  e_imm_q;
	logic        fw_valid_q;
	logic [3:0]  fw_pair_q;
	logic        fw_lo_q;
	logic        fw_hi_q;
	logic [15:0] fw_word_q;
	logic [15:0] xptr_q;
	logic [15:0] yptr_q;
	logic [15:0] pa;
	logic [15:0] pb;
	logic [7:0]  opa;
	logic [7:0]  opb;
	logic [7:0]  res_e;
	logic        carry_e;
	logic        shift_e;
	logic        wr_e;
	logic        pair_e;
	logic [7:0]  flags_e;
	logic        wr_en;
	logic [3:0]  wr_pair;
	logic        wr_lo;
	logic        wr_hi;
	logic [15:0] wr_word;
	logic [15:0] x_base;
	logic [15:0] y_base;
	logic [15:0] ptr_base;
	logic [15:0] load_addr;
	logic [15:0] ptr_new;
	logic [4:0]  load_rd_q;
	logic        load_done_q;
	logic        io_done_q;
	logic [2:0]  io_bit_q;
	logic        io_set_q;

	bfle_rf_if rf ();

	bfle_regfile bfle_regfile_inst (
		.clk_sys (clk_sys),
		.rst     (rst),
		.rf      (rf)
	);

	// ****************************************************************
	// decode helpers
	// ****************************************************************
	function automatic logic [7:0] bit_mask(input logic [2:0] b);
		bit_mask = 8'h01 << b;
	endfunction : bit_mask

	function automatic logic [15:0] merge(input logic [15:0] old, input logic lo,
		input logic hi, input logic [15:0] w);
		merge = {hi ? w[15:8] : old[15:8], lo ? w[7:0] : old[7:0]};
	endfunction : merge

	function automatic logic is_load(input bfle_op_t op);
		is_load = op inside {OP_LOAD_X, OP_LOAD_X_INC, OP_LOAD_X_DEC,
			OP_LOAD_Y, OP_LOAD_Y_INC, OP_LOAD_Y_DEC};
	endfunction : is_load

	function automatic logic is_post(input bfle_op_t op);
		is_post = op inside {OP_LOAD_X_INC, OP_LOAD_Y_INC};
	endfunction : is_post

	function automatic logic is_pre(input bfle_op_t op);
		is_pre = op inside {OP_LOAD_X_DEC, OP_LOAD_Y_DEC};
	endfunction : is_pre

	function automatic logic is_ymode(input bfle_op_t op);
		is_ymode = op inside {OP_LOAD_Y, OP_LOAD_Y_INC, OP_LOAD_Y_DEC};
	endfunction : is_ymode

	function automatic logic [15:0] fwd_pair(input logic [3:0] p, input logic [15:0] d);
		if (p == PAIR_X) begin
			fwd_pair = xptr_q;
		end else if (p == PAIR_Y) begin
			fwd_pair = yptr_q;
		end else if (fw_valid_q && fw_pair_q == p) begin
			fwd_pair = merge(d, fw_lo_q, fw_hi_q, fw_word_q);
		end else begin
			fwd_pair = d;
		end
	endfunction : fwd_pair

	assign acc   = instr_valid && instr_ready_q;
	assign io_op = (instr_op == OP_IO_BIT_SET) || (instr_op == OP_IO_BIT_CLEAR);
	assign k_ext = {{9{instr_k[6]}}, instr_k};

	// ****************************************************************
	// execute stage register
	// ****************************************************************
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			e_valid_q <= 1'b0;
			e_op_q    <= OP_NOP;
			e_rd_q    <= 5'h00;
			e_rr_q    <= 5'h00;
			e_bit_q   <= 3'h0;
			e_imm_q   <= BYTE_RST;
		end else begin
			e_valid_q <= acc;
			if (acc) begin
				e_op_q  <= instr_op;
				e_rd_q  <= instr_rd;
				e_rr_q  <= instr_rr;
				e_bit_q <= instr_bit;
				e_imm_q <= instr_imm;
			end
		end
	end

	// ****************************************************************
	// operands with forwarding
	// ****************************************************************
	assign rf.ra_pair = instr_rd[4:1];
	assign rf.rb_pair = instr_rr[4:1];
	// process form so that the pointer and forward registers read inside are watched
	always_comb begin
		pa = fwd_pair(e_rd_q[4:1], rf.ra_data);
		pb = fwd_pair(e_rr_q[4:1], rf.rb_data);
	end
	assign opa = e_rd_q[0] ? pa[15:8] : pa[7:0];
	assign opb = e_rr_q[0] ? pb[15:8] : pb[7:0];

	// ****************************************************************
	// single-cycle operations
	// ****************************************************************
	always_comb begin
		res_e   = opa;
		carry_e = 1'b0;
		shift_e = 1'b0;
		wr_e    = 1'b0;
		pair_e  = 1'b0;
		flags_e = status_flags_q;
		if (e_valid_q) begin
			case (e_op_q)
				OP_SHL: begin
					res_e   = {opa[6:0], 1'b0};
					carry_e = opa[7];
					shift_e = 1'b1;
				end
				OP_SHR: begin
					res_e   = {1'b0, opa[7:1]};
					carry_e = opa[0];
					shift_e = 1'b1;
				end
				OP_ROT_LEFT: begin
					res_e   = {opa[6:0], status_flags_q[FLAG_C]};
					carry_e = opa[7];
					shift_e = 1'b1;
				end
				OP_ROT_RIGHT: begin
					res_e   = {status_flags_q[FLAG_C], opa[7:1]};
					carry_e = opa[0];
					shift_e = 1'b1;
				end
				OP_SHR_ARITH: begin
					res_e   = {opa[7], opa[7:1]};
					carry_e = opa[0];
					shift_e = 1'b1;
				end
				OP_SWAP: begin
					res_e = {opa[3:0], opa[7:4]};
					wr_e  = 1'b1;
				end
				OP_REG_COPY: begin
					res_e = opb;
					wr_e  = 1'b1;
				end
				OP_LOAD_CONST: begin
					res_e = e_imm_q;
					wr_e  = 1'b1;
				end
				OP_PAIR_COPY: begin
					wr_e   = 1'b1;
					pair_e = 1'b1;
				end
				OP_T_TO_BIT: begin
					res_e = status_flags_q[FLAG_T] ? (opa | bit_mask(e_bit_q))
						: (opa & ~bit_mask(e_bit_q));
					wr_e  = 1'b1;
				end
				OP_BIT_TO_T: flags_e[FLAG_T] = |(opb & bit_mask(e_bit_q));
				OP_FLAG_SET: flags_e = status_flags_q | bit_mask(e_bit_q);
				OP_FLAG_CLR: flags_e = status_flags_q & ~bit_mask(e_bit_q);
				default: res_e = opa;
			endcase
		end
		if (shift_e) begin
			wr_e            = 1'b1;
			flags_e[FLAG_N] = res_e[7];
			flags_e[FLAG_Z] = (res_e == 8'h00);
			flags_e[FLAG_C] = carry_e;
			flags_e[FLAG_V] = res_e[7] ^ carry_e;
		end
	end

	// ****************************************************************
	// register write port
	// ****************************************************************
	always_comb begin
		wr_en   = wr_e;
		wr_pair = e_rd_q[4:1];
		wr_lo   = ~e_rd_q[0];
		wr_hi   = e_rd_q[0];
		wr_word = {res_e, res_e};
		if (pair_e) begin
			wr_word = pb;
			wr_lo   = 1'b1;
			wr_hi   = 1'b1;
		end
		if (load_done_q) begin
			wr_en   = 1'b1;
			wr_pair = load_rd_q[4:1];
			wr_lo   = ~load_rd_q[0];
			wr_hi   = load_rd_q[0];
			wr_word = {dm_rdata, dm_rdata};
		end
	end

	assign rf.we_lo = wr_en && wr_lo;
	assign rf.we_hi = wr_en && wr_hi;
	assign rf.wpair = wr_pair;
	assign rf.wword = wr_word;

	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			fw_valid_q <= 1'b0;
			fw_pair_q  <= 4'h0;
			fw_lo_q    <= 1'b0;
			fw_hi_q    <= 1'b0;
			fw_word_q  <= WORD_RST;
		end else begin
			fw_valid_q <= wr_en;
			fw_pair_q  <= wr_pair;
			fw_lo_q    <= wr_lo;
			fw_hi_q    <= wr_hi;
			fw_word_q  <= wr_word;
		end
	end

	// ****************************************************************
	// flags, branches and program counter
	// ****************************************************************
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			status_flags_q <= FLAGS_RST;
		end else begin
			status_flags_q <= flags_e;
		end
	end

	always_comb begin
		case (instr_op)
			OP_BR_IRQ_ON: take = flags_e[FLAG_I];
			OP_BR_IRQ_OFF: take = ~flags_e[FLAG_I];
			OP_BR_FLAG_SET: take = flags_e[instr_bit];
			OP_BR_FLAG_CLR: take = ~flags_e[instr_bit];
			default: take = 1'b0;
		endcase
	end

	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			pc_q          <= PC_RST;
			instr_ready_q <= 1'b0;
		end else if (acc) begin
			pc_q          <= take ? pc_q + 16'h0001 + k_ext : pc_q + 16'h0001;
			instr_ready_q <= !(take || io_op || is_load(instr_op));
		end else begin
			instr_ready_q <= 1'b1;
		end
	end

	// ****************************************************************
	// pointer loads
	// ****************************************************************
	assign x_base   = (wr_en && wr_pair == PAIR_X) ? merge(xptr_q, wr_lo, wr_hi, wr_word) : xptr_q;
	assign y_base   = (wr_en && wr_pair == PAIR_Y) ? merge(yptr_q, wr_lo, wr_hi, wr_word) : yptr_q;
	assign ptr_base = is_ymode(instr_op) ? y_base : x_base;
	assign load_addr = is_pre(instr_op) ? ptr_base - 16'h0001 : ptr_base;
	assign ptr_new   = is_post(instr_op) ? ptr_base + 16'h0001 : load_addr;

	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			xptr_q <= PTR_RST;
			yptr_q <= PTR_RST;
		end else begin
			xptr_q <= (acc && is_load(instr_op) && !is_ymode(instr_op)) ? ptr_new : x_base;
			yptr_q <= (acc && is_load(instr_op) && is_ymode(instr_op)) ? ptr_new : y_base;
		end
	end

	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			dm_re_q   <= 1'b0;
			dm_addr_q <= PTR_RST;
			load_rd_q   <= 5'h00;
			load_done_q <= 1'b0;
		end else begin
			dm_re_q     <= acc && is_load(instr_op);
			load_done_q <= dm_re_q;
			if (acc && is_load(instr_op)) begin
				dm_addr_q <= load_addr;
				load_rd_q <= instr_rd;
			end
		end
	end

	// ****************************************************************
	// I/O bit read-modify-write
	// ****************************************************************
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			io_re_q    <= 1'b0;
			io_done_q  <= 1'b0;
			io_we_q    <= 1'b0;
			io_addr_q  <= 5'h00;
			io_wdata_q <= BYTE_RST;
			io_bit_q   <= 3'h0;
			io_set_q   <= 1'b0;
		end else begin
			io_re_q   <= acc && io_op;
			io_done_q <= io_re_q;
			io_we_q   <= io_done_q;
			if (acc && io_op) begin
				io_addr_q <= instr_io;
				io_bit_q  <= instr_bit;
				io_set_q  <= (instr_op == OP_IO_BIT_SET);
			end
			if (io_done_q) begin
				io_wdata_q <= io_set_q ? (io_rdata | bit_mask(io_bit_q))
					: (io_rdata & ~bit_mask(io_bit_q));
			end
		end
	end

	// ****************************************************************
	// assertions
	// ****************************************************************
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (rst);

	sequence s_one_stall;
		!instr_ready_q ##1 instr_ready_q;
	endsequence

	sequence s_io_rmw;
		io_re_q ##1 !io_we_q ##1 io_we_q;
	endsequence

	AST_BR_IRQ_ON: assert property (acc && instr_op == OP_BR_IRQ_ON && flags_e[FLAG_I]
		|=> pc_q == $past(pc_q) + 16'h0001 + $past(k_ext) && status_flags_q == $past(flags_e)
		##0 s_one_stall) else $error("irq-on branch not taken");
	AST_BR_IRQ_OFF: assert property (acc && instr_op == OP_BR_IRQ_OFF && flags_e[FLAG_I]
		|=> instr_ready_q && pc_q == $past(pc_q) + 16'h0001) else $error("irq-off fall through");
	AST_BR_FLAG: assert property (acc && instr_op == OP_BR_FLAG_CLR && !flags_e[instr_bit]
		|=> pc_q == $past(pc_q) + 16'h0001 + $past(k_ext)) else $error("flag branch not taken");
	AST_IO_BIT: assert property (acc && instr_op == OP_IO_BIT_CLEAR |=> s_io_rmw
		##0 (io_wdata_q & bit_mask($past(instr_bit, 3))) == 8'h00 && io_addr_q == $past(instr_io, 3))
		else $error("io bit clear wrong");
	AST_SHL: assert property (e_valid_q && e_op_q == OP_SHL |=>
		status_flags_q[FLAG_C] == $past(opa[7]) && status_flags_q[FLAG_Z] == ($past(opa[6:0]) == 7'h00)
		&& fw_word_q[7:0] == {$past(opa[6:0]), 1'b0}) else $error("shift left wrong");
	AST_SHR: assert property (e_valid_q && e_op_q == OP_SHR |=> !status_flags_q[FLAG_N]
		&& status_flags_q[FLAG_V] == $past(opa[0])) else $error("shift right flags wrong");
	AST_ROT_LEFT: assert property (e_valid_q && e_op_q == OP_ROT_LEFT |=>
		status_flags_q[FLAG_C] == $past(opa[7]) && status_flags_q[FLAG_Z] ==
		($past(opa[6:0]) == 7'h00 && !$past(status_flags_q[FLAG_C]))) else $error("rotate left wrong");
	AST_ROT_RIGHT: assert property (e_valid_q && e_op_q == OP_ROT_RIGHT |=>
		status_flags_q[FLAG_N] == $past(status_flags_q[FLAG_C])
		&& status_flags_q[FLAG_C] == $past(opa[0])) else $error("rotate right wrong");
	AST_SHR_ARITH: assert property (e_valid_q && e_op_q == OP_SHR_ARITH |=>
		status_flags_q[FLAG_N] == $past(opa[7])) else $error("sign bit lost");
	AST_FLAG_ONLY: assert property (e_valid_q && e_op_q == OP_FLAG_SET |=>
		((status_flags_q ^ $past(status_flags_q)) & ~bit_mask($past(e_bit_q))) == 8'h00
		&& (status_flags_q & bit_mask($past(e_bit_q))) != 8'h00) else $error("flag set wrong");
	AST_BIT_TO_T: assert property (e_valid_q && e_op_q == OP_BIT_TO_T |=>
		status_flags_q[FLAG_T] == |($past(opb) & bit_mask($past(e_bit_q)))
		&& status_flags_q[5:0] == $past(status_flags_q[5:0])) else $error("bit to T wrong");
	AST_NO_FLAGS: assert property (e_valid_q && e_op_q inside {OP_T_TO_BIT, OP_REG_COPY,
		OP_PAIR_COPY, OP_LOAD_CONST, OP_SWAP} |=> status_flags_q == $past(status_flags_q))
		else $error("flags changed");
	AST_LOAD_X_INC: assert property (acc && instr_op == OP_LOAD_X_INC |=> dm_re_q
		&& dm_addr_q == $past(x_base) && xptr_q == dm_addr_q + 16'h0001 ##0 s_one_stall)
		else $error("post-increment load wrong");
	AST_LOAD_X_DEC: assert property (acc && instr_op == OP_LOAD_X_DEC |=> dm_re_q
		&& xptr_q == $past(x_base) - 16'h0001 && dm_addr_q == xptr_q) else $error("pre-decrement X");
	AST_LOAD_Y_INC: assert property (acc && instr_op == OP_LOAD_Y_INC |=>
		dm_addr_q == $past(y_base) && yptr_q == dm_addr_q + 16'h0001) else $error("Y post-increment");
	AST_LOAD_Y_DEC: assert property (acc && instr_op == OP_LOAD_Y_DEC |=>
		yptr_q == $past(y_base) - 16'h0001 && dm_addr_q == yptr_q) else $error("Y pre-decrement");
	AST_LOAD_DONE: assert property (acc && is_load(instr_op) |=> s_one_stall
		##0 load_done_q && rf.we_lo != rf.we_hi) else $error("load not written");
endmodule : bfle_exec

`default_nettype wire

// ==== bfle_mem_model.sv ====
// Purpose: data memory and I/O space facing the executor
// Assumes: answers one cycle after each read strobe
// Notes:   idle read lines toggle so stale data never looks valid
`timescale 1ns/10ps
`default_nettype none

module bfle_mem_model (
	input  wire logic        clk_sys,
	input  wire logic        rst,
	input  wire logic [4:0]  io_addr_q,
	input  wire logic [7:0]  io_wdata_q,
	input  wire logic        io_we_q,
	input  wire logic        io_re_q,
	output logic [7:0]       io_rdata,
	input  wire logic [15:0] dm_addr_q,
	input  wire logic        dm_re_q,
	output logic [7:0]       dm_rdata
);
	logic [7:0] io_mem [32];

	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			for (int i = 0; i < 32; i++) begin
				io_mem[i] <= 8'h00;
			end
			io_rdata <= 8'h00;
			dm_rdata <= 8'h00;
		end else begin
			if (io_we_q) begin
				io_mem[io_addr_q] <= io_wdata_q;
			end
			// write first when read and write meet
			io_rdata <= io_re_q ? (io_we_q ? io_wdata_q : io_mem[io_addr_q]) : ~io_rdata;
			dm_rdata <= dm_re_q ? (dm_addr_q[7:0] ^ dm_addr_q[15:8] ^ 8'h5A) : ~dm_rdata;
		end
	end
endmodule : bfle_mem_model

`default_nettype wire

// ==== bfle_exec_bench.sv ====
// Purpose: random self-checking bench of the executor
// Assumes: registers observed through the transfer flag, flags read directly from status_flags_q
// Notes:   memory data is a fixed function of the address
`timescale 1ns/10ps
`default_nettype none

module bfle_exec_bench;
	import bfle_pkg::*;
	logic        clk_sys;
	logic        rst;
	logic        instr_valid;
	bfle_op_t    instr_op;
	logic [4:0]  instr_rd;
	logic [4:0]  instr_rr;
	logic [2:0]  instr_bit;
	logic [7:0]  instr_imm;
	logic [6:0]  instr_k;
	logic [4:0]  instr_io;
	logic        instr_ready_q;
	logic [15:0] pc_q;
	logic [7:0]  status_flags_q;
	logic [4:0]  io_addr_q;
	logic [7:0]  io_wdata_q;
	logic        io_we_q;
	logic        io_re_q;
	logic [7:0]  io_rdata;
	logic [15:0] dm_addr_q;
	logic        dm_re_q;
	logic [7:0]  dm_rdata;
	int          error_cnt;
	int          checks;
	int          lo;
	logic [15:0] rnd;
	logic [15:0] p;
	logic [15:0] a;
	logic [7:0]  exp_f;
	logic [7:0]  io_exp [32];
	logic [7:0]  v;
	logic [7:0]  w;
	logic [4:0]  d;
	logic [4:0]  e;
	logic [2:0]  b;
	logic [2:0]  b2;
	logic [1:0]  m;
	logic        c;
	logic        tk;
	bfle_op_t    op;

	bfle_exec bfle_exec_inst (.clk_sys, .rst, .instr_valid, .instr_op, .instr_rd, .instr_rr,
		.instr_bit, .instr_imm, .instr_k, .instr_io, .instr_ready_q, .pc_q, .status_flags_q,
		.io_addr_q, .io_wdata_q, .io_we_q, .io_re_q, .io_rdata, .dm_addr_q, .dm_re_q, .dm_rdata);
	bfle_mem_model bfle_mem_model_inst (.clk_sys, .rst, .io_addr_q, .io_wdata_q, .io_we_q,
		.io_re_q, .io_rdata, .dm_addr_q, .dm_re_q, .dm_rdata);

	function automatic logic [7:0] r8();
		rnd = {rnd[14:0], rnd[15] ^ rnd[13] ^ rnd[12] ^ rnd[10]};
		return rnd[7:0];
	endfunction : r8

	function automatic logic [8:0] shf(input bfle_op_t o, input logic [7:0] x, input logic ci);
		case (o)
			OP_SHL: return {x[7], x[6:0], 1'b0};
			OP_SHR: return {x[0], 1'b0, x[7:1]};
			OP_ROT_LEFT: return {x[7], x[6:0], ci};
			OP_ROT_RIGHT: return {x[0], ci, x[7:1]};
			default: return {x[0], x[7], x[7:1]};
		endcase
	endfunction : shf

	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		checks++;
		if (got !== exp) begin
			error_cnt++;
			$display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk

	task automatic results();
		$display("errors=%0d checks=%0d", error_cnt, checks);
		if (error_cnt == 0 && checks > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask : results

	// offer one operation and hold it until taken
	task automatic iss(input bfle_op_t o, input logic [4:0] rd, input logic [4:0] rr,
		input logic [2:0] bt, input logic [7:0] imm, input logic [6:0] k);
		int n;
		if (!instr_valid)
			@(posedge clk_sys);
		instr_valid <= 1'b1;
		instr_op <= o;
		instr_rd <= rd;
		instr_rr <= rr;
		instr_bit <= bt;
		instr_imm <= imm;
		instr_k <= k;
		instr_io <= rd;
		n = 0;
		do @(posedge clk_sys); while (instr_ready_q !== 1'b1 && ++n < 20);
		if (n >= 20) begin
			error_cnt++;
			results();
		end
	endtask : iss

	task automatic idle(input int n);
		instr_valid <= 1'b0;
		repeat (n) @(posedge clk_sys);
		#1;
	endtask : idle

	// read a register bit by bit through the transfer flag
	task automatic rd_chk(input logic [4:0] r, input logic [7:0] ex);
		logic [7:0] got;
		for (int i = 0; i < 8; i++) begin
			iss(OP_BIT_TO_T, '0, r, 3'(i), '0, '0);
			idle(2);
			got[i] = status_flags_q[FLAG_T];
		end
		chk(16'(got), 16'(ex));
		exp_f[FLAG_T] = ex[7];
		chk(16'(status_flags_q), 16'(exp_f));
	endtask : rd_chk

	initial begin
		clk_sys = 1'b0;
		forever #12.5 clk_sys = ~clk_sys;
	end

	initial begin
		repeat (30000) @(posedge clk_sys);
		error_cnt++;
		results();
	end

	initial begin
		rst = 1'b1;
		instr_valid = 1'b0;
		instr_op = OP_NOP;
		instr_rd = '0;
		instr_rr = '0;
		instr_bit = '0;
		instr_imm = '0;
		instr_k = '0;
		instr_io = '0;
		error_cnt = 0;
		checks = 0;
		rnd = 16'd80;
		exp_f = FLAGS_RST;
		for (int i = 0; i < 32; i++) begin
			io_exp[i] = 8'h00;
		end
		repeat (10) @(posedge clk_sys);
		rst <= 1'b0;
		for (int j = 0; j < 16; j++) begin
			iss(j[0] ? OP_FLAG_CLR : OP_FLAG_SET, '0, '0, j[3:1], '0, '0);
			exp_f[j[3:1]] = !j[0];
			idle(2);
			chk(16'(status_flags_q), 16'(exp_f));
		end
		for (int i = 0; i < 90; i++) begin
			v = r8();
			w = r8();
			case (v % 8'h06)
				0: begin
					iss(w[3] ? OP_FLAG_SET : OP_FLAG_CLR, '0, '0, w[2:0], '0, '0);
					exp_f[w[2:0]] = w[3];
					idle(2);
					chk(16'(status_flags_q), 16'(exp_f));
				end
				1: begin
					d = {2'b10, w[2:0]};
					iss(w[3] ? OP_FLAG_SET : OP_FLAG_CLR, '0, '0, 3'(FLAG_C), '0, '0);
					iss(OP_LOAD_CONST, d, '0, '0, v, '0);
					op = bfle_op_t'(OP_SHL + (w[6:4] % 3'd5));
					iss(op, d, '0, '0, '0, '0);
					idle(2);
					{c, v} = shf(op, v, w[3]);
					exp_f[FLAG_C] = c;
					exp_f[FLAG_Z] = (v == 8'h00);
					exp_f[FLAG_N] = v[7];
					exp_f[FLAG_V] = v[7] ^ c;
					chk(16'(status_flags_q), 16'(exp_f));
					rd_chk(d, v);
				end
				2: begin
					op = bfle_op_t'(OP_BR_IRQ_ON + v[1:0]);
					b = v[1] ? v[4:2] : 3'(FLAG_I);
					tk = exp_f[b] ^ v[0];
					p = pc_q;
					iss(op, '0, '0, b, '0, w[6:0]);
					instr_valid <= 1'b0;
					lo = 0;
					repeat (3) begin
						#1;
						lo += (instr_ready_q === 1'b0);
						@(posedge clk_sys);
					end
					#1;
					chk(pc_q, p + 16'd1 + (tk ? {{9{w[6]}}, w[6:0]} : 16'h0000));
					chk(16'(lo), 16'(tk));
					chk(16'(status_flags_q), 16'(exp_f));
				end
				3: begin
					d = {2'b10, w[2:0]};
					e = {2'b11, w[5:3]};
					b = v[5:3];
					b2 = w[7:5];
					iss(OP_LOAD_CONST, d, '0, '0, v, '0);
					iss(OP_LOAD_CONST, e, '0, '0, w, '0);
					iss(OP_BIT_TO_T, '0, d, b, '0, '0);
					iss(OP_T_TO_BIT, e, '0, b2, '0, '0);
					iss(OP_REG_COPY, d, e, '0, '0, '0);
					idle(2);
					exp_f[FLAG_T] = v[b];
					w[b2] = v[b];
					chk(16'(status_flags_q), 16'(exp_f));
					rd_chk(d, w);
					iss(OP_SWAP, e, '0, '0, '0, '0);
					rd_chk(e, {w[3:0], w[7:4]});
					iss(OP_PAIR_COPY, 5'd30, {d[4:1], 1'b0}, '0, '0, '0);
					rd_chk({4'hF, d[0]}, w);
				end
				4: begin
					d = v[4:0];
					iss(w[3] ? OP_IO_BIT_SET : OP_IO_BIT_CLEAR, d, '0, v[7:5], '0, '0);
					iss(w[4] ? OP_IO_BIT_SET : OP_IO_BIT_CLEAR, d, '0, w[2:0], '0, '0);
					io_exp[d][v[7:5]] = w[3];
					io_exp[d][w[2:0]] = w[4];
					idle(4);
					chk(16'(bfle_mem_model_inst.io_mem[d]), 16'(io_exp[d]));
					chk(16'(status_flags_q), 16'(exp_f));
				end
				default: begin
					p = (v[7:5] == 3'h0) ? {16{v[0]}} : {v, w};
					e = v[1] ? 5'd28 : 5'd26;
					m = v[3:2] % 2'd3;
					op = bfle_op_t'((v[1] ? OP_LOAD_Y : OP_LOAD_X) + m);
					d = {2'b10, w[2:0]};
					iss(OP_LOAD_CONST, e, '0, '0, p[7:0], '0);
					iss(OP_LOAD_CONST, e + 5'd1, '0, '0, p[15:8], '0);
					iss(op, d, '0, '0, '0, '0);
					idle(4);
					a = (m == 2'd2) ? p - 16'd1 : p;
					chk(dm_addr_q, a);
					rd_chk(d, a[7:0] ^ a[15:8] ^ 8'h5A);
					p = (m == 2'd1) ? p + 16'd1 : a;
					rd_chk(e, p[7:0]);
					rd_chk(e + 5'd1, p[15:8]);
				end
			endcase
		end
		results();
	end
endmodule : bfle_exec_bench

`default_nettype wire
